// [drs_pkg.sv]
// package: register map, strap layout and constants for the drive role strap decoder
package drs_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_STRAPS = 4'h8;

  // ctrl fields
  localparam int CTRL_DIAG_PASS = 0;  // slave reports diagnostics passed on PDIAG-
  localparam int CTRL_ANNOUNCE  = 1;  // slave announces itself on DASP-
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status fields
  localparam int ST_LATCHED   = 0;
  localparam int ST_MASTER    = 1;
  localparam int ST_CS_MODE   = 2;
  localparam int ST_SLAVE_PRS = 3;  // write one to clear
  localparam int ST_CONFLICT  = 4;
  localparam int ST_PDIAG_DRV = 5;
  localparam int ST_DASP_DRV  = 6;
  localparam int ST_PDIAG_LVL = 7;

  // ----------------------------------------------------------------
  // strap and pin layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cableSelLevel;    // level on the cable-select pin
    logic secondDriveStrap; // 1 = installed
    logic roleStrap;        // 1 = installed
    logic cableRoleStrap;   // 1 = installed
  } drs_cfg_t;

  // factory default: only the role strap installed, so a fresh part is master
  localparam drs_cfg_t CFG_FACTORY = '{cableSelLevel: 1'b1, secondDriveStrap: 1'b0,
                                       roleStrap: 1'b1, cableRoleStrap: 1'b0};

  localparam int          SYNC_STAGES = 2;
  localparam logic [1:0]  SETTLE_CYC  = 2'h3;  // sync depth plus one edge of margin
  localparam int          PIN_W       = 6;

endpackage

// [drs_sync.sv]
// module: two-flop synchroniser for a vector of slow pin levels
module drs_sync #(
  parameter int WIDTH = 1
) (
  // clocking
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // levels
  input  wire logic [WIDTH-1:0] pinRaw,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // two stages; the first is read by the second only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1  <= '0;
      pinSync <= '0;
    end else if (ce) begin
      stage1  <= pinRaw;
      pinSync <= stage1;
    end
  end

endmodule

// [drs_role_decode.sv]
// module: drive role strap decoder with wishbone status and control registers
//
// Design decisions made here: the Wishbone slave port and the register addresses.
module drs_role_decode
  import drs_pkg::*;
(
  // clocking
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // strap pins (1 = installed)
  input  wire logic        cableRoleStrap,
  input  wire logic        roleStrap,
  input  wire logic        secondDriveStrap,
  // cable-select pin
  input  wire logic        cableSelIn,
  output logic             cableSelPullEn,
  // open-drain PDIAG- and DASP- lines
  input  wire logic        pdiagIn_n,
  output logic             pdiagOut_n,
  output logic             pdiagOe,
  input  wire logic        daspIn_n,
  output logic             daspOut_n,
  output logic             daspOe,
  // role
  output logic             isMaster,
  output logic             roleLatched
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pinSync;
  drs_cfg_t         cfgSync;
  logic             daspSync_n;
  logic             pdiagSync_n;

  drs_sync #(.WIDTH(PIN_W)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ce      (ce),
    .pinRaw  ({pdiagIn_n, daspIn_n, cableSelIn, secondDriveStrap, roleStrap, cableRoleStrap}),
    .pinSync (pinSync)
  );

  assign cfgSync     = drs_cfg_t'(pinSync[3:0]);
  assign daspSync_n  = pinSync[4];
  assign pdiagSync_n = pinSync[5];

  // ----------------------------------------------------------------
  // capture after reset release
  // ----------------------------------------------------------------
  drs_cfg_t   cfg;
  logic [1:0] settleCnt;
  logic       next_master;

  // role from straps; both strap sets fitted falls back to the role strap
  always_comb begin
    if (cfgSync.cableRoleStrap && !cfgSync.roleStrap)
      next_master = !cfgSync.cableSelLevel;
    else
      next_master = cfgSync.roleStrap;
  end

  // settle counter lets the synchroniser fill before the one-shot capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      settleCnt <= 2'h0;
    end else if (ce && !roleLatched) begin
      settleCnt <= settleCnt + 2'h1;
    end
  end

  // role and config stay fixed until the next reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg         <= CFG_FACTORY;
      isMaster    <= 1'b1;
      roleLatched <= 1'b0;
    end else if (ce && !roleLatched && settleCnt == SETTLE_CYC) begin
      cfg         <= cfgSync;
      isMaster    <= next_master;
      roleLatched <= 1'b1;
    end
  end

  // pull-up on cable-select is on from reset onward
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cableSelPullEn <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control register and slave presence
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic       slavePresent;
  logic       busWrite;
  logic       clearPresent;

  // writes land at the edge that sees ack high, while the master still holds the request
  assign busWrite     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && ce;
  assign clearPresent = busWrite && wb_adr_i == ADDR_STATUS && wb_sel_i[0]
                        && wb_dat_i[ST_SLAVE_PRS];

  // ctrl write, byte lane 0 only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (busWrite && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // sticky presence; a detection in the clear cycle wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slavePresent <= 1'b0;
    end else if (ce && roleLatched && isMaster && cfg.secondDriveStrap) begin
      slavePresent <= 1'b1;
    end else if (ce && roleLatched && isMaster && !daspSync_n) begin
      slavePresent <= 1'b1;
    end else if (clearPresent) begin
      slavePresent <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // open-drain line drive, low when enabled
  // ----------------------------------------------------------------
  logic slaveTalks;
  assign slaveTalks = roleLatched && !isMaster && !cfg.secondDriveStrap;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pdiagOe    <= 1'b0;
      daspOe     <= 1'b0;
      pdiagOut_n <= 1'b0;
      daspOut_n  <= 1'b0;
    end else if (ce) begin
      pdiagOe    <= slaveTalks && ctrl[CTRL_DIAG_PASS];
      daspOe     <= slaveTalks && ctrl[CTRL_ANNOUNCE];
      pdiagOut_n <= 1'b0;
      daspOut_n  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wishbone read and ack, registered, so one wait cycle
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_CTRL:   next_rdata[1:0] = ctrl;
      ADDR_STATUS: begin
        next_rdata[ST_LATCHED]   = roleLatched;
        next_rdata[ST_MASTER]    = isMaster;
        next_rdata[ST_CS_MODE]   = cfg.cableRoleStrap && !cfg.roleStrap;
        next_rdata[ST_SLAVE_PRS] = slavePresent;
        next_rdata[ST_CONFLICT]  = cfg.cableRoleStrap && cfg.roleStrap;
        next_rdata[ST_PDIAG_DRV] = pdiagOe;
        next_rdata[ST_DASP_DRV]  = daspOe;
        next_rdata[ST_PDIAG_LVL] = pdiagSync_n;
      end
      ADDR_STRAPS: next_rdata[3:0] = cfg;
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  // ack lasts one cycle; unmapped addresses are acked with zero data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_strap_master;
    @(posedge sys_clk) disable iff (reset)
    roleLatched && !cfg.cableRoleStrap && cfg.roleStrap |-> isMaster;
  endproperty
  a_strap_master: assert property (p_strap_master) else $error("role strap 1 not master");

  property p_strap_slave;
    @(posedge sys_clk) disable iff (reset)
    roleLatched && !cfg.cableRoleStrap && !cfg.roleStrap |-> !isMaster;
  endproperty
  a_strap_slave: assert property (p_strap_slave) else $error("role strap 0 not slave");

  property p_cs_low_master;
    @(posedge sys_clk) disable iff (reset)
    roleLatched && cfg.cableRoleStrap && !cfg.roleStrap && !cfg.cableSelLevel |-> isMaster;
  endproperty
  a_cs_low_master: assert property (p_cs_low_master) else $error("cable-select low not master");

  property p_cs_high_slave;
    @(posedge sys_clk) disable iff (reset)
    roleLatched && cfg.cableRoleStrap && !cfg.roleStrap && cfg.cableSelLevel |-> !isMaster;
  endproperty
  a_cs_high_slave: assert property (p_cs_high_slave) else $error("cable-select high not slave");

  property p_reset_default;
    @(posedge sys_clk) reset |=> isMaster && !roleLatched && cableSelPullEn;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("reset default not master");

  property p_quiet_slave;
    @(posedge sys_clk) disable iff (reset)
    roleLatched && !isMaster && cfg.secondDriveStrap |=> !pdiagOe && !daspOe;
  endproperty
  a_quiet_slave: assert property (p_quiet_slave) else $error("slave drives lines with strap");

  property p_strap_present;
    @(posedge sys_clk) disable iff (reset)
    ce && roleLatched && isMaster && cfg.secondDriveStrap |=> slavePresent;
  endproperty
  a_strap_present: assert property (p_strap_present) else $error("strap presence missed");

  property p_dasp_present;
    @(posedge sys_clk) disable iff (reset)
    ce && roleLatched && isMaster && !daspSync_n |=> slavePresent;
  endproperty
  a_dasp_present: assert property (p_dasp_present) else $error("DASP- presence missed");

  property p_role_hold;
    @(posedge sys_clk) disable iff (reset)
    roleLatched |=> roleLatched && $stable(isMaster) && $stable(cfg);
  endproperty
  a_role_hold: assert property (p_role_hold) else $error("role changed after capture");

  property p_capture_time;
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) ##0 ce [*4] |=> roleLatched;
  endproperty
  a_capture_time: assert property (p_capture_time) else $error("role not captured in time");

  property p_master_pdiag;
    @(posedge sys_clk) disable iff (reset)
    roleLatched && isMaster |=> !pdiagOe && !daspOe;
  endproperty
  a_master_pdiag: assert property (p_master_pdiag) else $error("master drives PDIAG- or DASP-");

endmodule

// [drs_far_side.sv]
// far side model: host cable position and companion drive on the wired lines
module drs_far_side (
  // clocking
  input  wire logic sys_clk,
  // cable and companion behaviour
  input  wire logic atFirst,
  input  wire logic compAnnounce,
  input  wire logic compDiag,
  // design side of the pins
  input  wire logic cableSelPullEn,
  input  wire logic pdiagOe,
  input  wire logic pdiagOut_n,
  input  wire logic daspOe,
  input  wire logic daspOut_n,
  output logic      cableSelIn,
  output logic      pdiagIn_n,
  output logic      daspIn_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // wired levels
  // ----------------------------------------------------------------
  logic floatPat = 1'b0;

  // an open pin with no pull has no level, so it wanders every cycle
  always @(posedge sys_clk) floatPat <= ~floatPat;

  // host end grounds the line, second connector sees the cut line
  assign cableSelIn = atFirst ? 1'b0 : (cableSelPullEn ? 1'b1 : floatPat);
  // bus pull-ups hold both lines high unless someone pulls low
  assign pdiagIn_n  = !((pdiagOe && !pdiagOut_n) || compDiag);
  assign daspIn_n   = !((daspOe && !daspOut_n) || compAnnounce);
endmodule

// [tb.sv]
// self-checking bench for the drive role strap decoder
module tb
  import drs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk, reset, ce, wbCyc, wbStb, wbWe, cr, rs, sdStrap, atFirst, ann, diag;
  logic [3:0]  wbAdr, wbSel;
  logic [31:0] wbDat, rdat, seed;
  logic [31:0] datO;
  logic        ack, csIn, pullEn, pdIn, pdOut, pdOe, daspIn, daspOut, daspOe, isMaster, latched;
  logic        expM;
  logic [1:0]  d, expOe;
  logic [6:0]  expSt, mask;
  int          nFail, nChecks, i, k, c;

  drs_role_decode u_dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(datO), .wb_ack_o(ack), .cableRoleStrap(cr), .roleStrap(rs),
    .secondDriveStrap(sdStrap), .cableSelIn(csIn), .cableSelPullEn(pullEn), .pdiagIn_n(pdIn),
    .pdiagOut_n(pdOut), .pdiagOe(pdOe), .daspIn_n(daspIn), .daspOut_n(daspOut),
    .daspOe(daspOe),
    .isMaster(isMaster), .roleLatched(latched));
  drs_far_side u_far (.sys_clk(sys_clk), .atFirst(atFirst), .compAnnounce(ann),
    .compDiag(diag), .cableSelPullEn(pullEn), .pdiagOe(pdOe), .pdiagOut_n(pdOut),
    .daspOe(daspOe), .daspOut_n(daspOut), .cableSelIn(csIn), .pdiagIn_n(pdIn),
    .daspIn_n(daspIn));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // role strap wins unless only the cable-role strap is fitted
  function automatic logic role(input logic c_r, input logic r_s, input logic cs);
    return (c_r && !r_s) ? !cs : r_s;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= a;
    wbDat <= dv;
    // no fixed latency assumed; only the watchdog ends a hung wait
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = datO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic giveVerdict();
    if (nFail == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {wbCyc, wbStb, wbWe, cr, sdStrap, ann, diag} = '0;
    {wbAdr, wbDat} = '0;
    wbSel = 4'hF;
    ce = 1'b1;
    reset = 1'b1;
    rs = 1'b1;
    atFirst = 1'b1;
    seed = 32'he353;
    repeat (20) @(posedge sys_clk);
    chk("isMaster", isMaster, 1'b1);
    // combos skip both role straps fitted together
    for (i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      c = (i < 12) ? i : int'(seed[7:0]) % 12;
      // cable-select level is high only at the cut second connector
      expM = role(c % 3 == 2, c % 3 == 1, c >= 6);
      d = seed[9:8];
      cr <= (c % 3 == 2);
      rs <= (c % 3 == 1);
      sdStrap <= 1'((c / 3) % 2); // set when companion cannot announce
      atFirst <= (c < 6);
      ann <= seed[4] && expM;
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      // one pass holds the clock enable low: the capture must wait for it
      if (i == 3) begin
        ce <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk("frozen", latched, 1'b0);
        ce <= 1'b1;
      end
      for (k = 0; k < 10 && latched !== 1'b1; k++) @(posedge sys_clk);
      chk("isMaster", isMaster, expM);
      chk("pullEn", pullEn, 1'b1);
      wb(1'b0, ADDR_STRAPS, 32'h0);
      chk("straps", rdat, {28'h0, !atFirst, sdStrap, rs, cr});
      wb(1'b1, ADDR_CTRL, {seed[31:10], 8'h0, d});
      wb(1'b1, 4'hC, 32'hFFFF_FFFF);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", rdat, {30'h0, d});
      wb(1'b0, 4'hC, 32'h0);
      chk("unmapped", rdat, 32'h0);
      // only a slave without the second-drive strap touches the lines
      expOe = (!expM && !sdStrap) ? d : 2'b00;
      chk("lineOe", {daspOe, pdOe}, expOe);
      wb(1'b0, ADDR_STATUS, 32'h0);
      expSt = {expOe, 1'b0, sdStrap | ann, cr & !rs, expM, 1'b1};
      mask = expM ? 7'h7F : 7'h77;
      chk("status", rdat[6:0] & mask, expSt & mask);
      // companion goes quiet; once the synchroniser has drained, clear presence
      ann <= 1'b0;
      repeat (3) @(posedge sys_clk);
      wb(1'b1, ADDR_STATUS, 32'h0000_0008);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk("present", rdat[3], expM & sdStrap);
      rs <= !rs;
      atFirst <= !atFirst;
      repeat (6) @(posedge sys_clk);
      chk("isMaster", isMaster, expM);
    end
    giveVerdict();
  end

  // hang guard, well beyond the roughly 1000 cycles the run needs
  initial begin
    nFail = 0;
    nChecks = 0;
    repeat (20000) @(posedge sys_clk);
    nFail++;
    giveVerdict();
  end
endmodule
